// ===== ucfd_map.svh
// Offsets, field positions, reset values and store constants for the config decoder.
// Assumes inclusion by bare name from package or module files.
`ifndef UCFD_MAP_SVH
`define UCFD_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses on APB)
// ****************************************************************
`define UCFD_OFF_GENERAL 12'h000
`define UCFD_OFF_TXTUNE 12'h004
`define UCFD_OFF_CTRL 12'h008
`define UCFD_OFF_STATUS 12'h00C

// ****************************************************************
// Field positions of the general word
// ****************************************************************
`define UCFD_GEN_SWAP 12
`define UCFD_GEN_SWMODE_LVL 11
`define UCFD_GEN_LED_PP 10
`define UCFD_GEN_LED_LVL 9
`define UCFD_GEN_LED_EN 8
`define UCFD_GEN_IRQ_LVL 7
`define UCFD_GEN_XRST_LVL 6
`define UCFD_GEN_SQ_HI 5
`define UCFD_GEN_SQ_LO 4
`define UCFD_GEN_LPM 3
`define UCFD_GEN_BOOST_HI 2
`define UCFD_GEN_BOOST_LO 1
`define UCFD_GEN_SELFPWR 0
`define UCFD_GEN_MASK 32'h00001FFF

// ****************************************************************
// Field positions of the tuning word
// ****************************************************************
`define UCFD_TX_DE35_HI 29
`define UCFD_TX_DE35_LO 24
`define UCFD_TX_DE6_HI 21
`define UCFD_TX_DE6_LO 16
`define UCFD_TX_FULL_HI 14
`define UCFD_TX_FULL_LO 8
`define UCFD_TX_LOW_HI 6
`define UCFD_TX_LOW_LO 0
`define UCFD_TX_MASK 32'h3F3F7F7F

// ****************************************************************
// Reset values and store constants
// ****************************************************************
`define UCFD_GEN_DEFAULT 32'h00000008
`define UCFD_TX_DEFAULT 32'h16206935
`define UCFD_SIGNATURE 8'hA5
`define UCFD_CTRL_RELOAD 0
`define UCFD_LOAD_WORDS 3'h3

`endif

// ===== ucfd_pkg.sv
// Types shared by the config decoder files.
// Assumes ucfd_map.svh is reachable by bare name.
package ucfd_pkg;

    // Loader states, Gray coded along the load path
    typedef enum logic [2:0]
    {
        UCFD_IDLE = 3'b000,
        UCFD_SIG = 3'b001,
        UCFD_GEN = 3'b011,
        UCFD_TX = 3'b010,
        UCFD_DONE = 3'b110
    } ucfd_state_e;

    typedef logic [31:0] ucfd_word_t;

endpackage

// ===== ucfd_store_if.sv
// Interface carrying store reads between loader and decoder top.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface ucfd_store_if;
    logic req;
    logic [1:0] addr;
    logic ack;
    logic [31:0] data;

    modport loader
    (
        output req,
        output addr,
        input ack,
        input data
    );
    modport top
    (
        input req,
        input addr,
        output ack,
        output data
    );
endinterface
`default_nettype wire

// ===== ucfd_loader.sv
// Load sequencer: reads signature, then both words from the store only if it matches.
// Assumes the store answers each request with a one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
`include "ucfd_map.svh"
module ucfd_loader
    import ucfd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic start,
    ucfd_store_if.loader st,
    output logic loadGen,
    output logic loadTx,
    output logic useDefault,
    output logic busy
);

    ucfd_state_e state_q;
    ucfd_state_e state_d;
    logic valid_q;
    logic valid_d;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Next state and strobes
    always_comb
    begin
        state_d = state_q;
        valid_d = valid_q;
        loadGen = 1'b0;
        loadTx = 1'b0;
        useDefault = 1'b0;
        st.req = 1'b0;
        st.addr = 2'h0;
        case (state_q)
            UCFD_IDLE:
            begin
                if (start)
                begin
                    state_d = UCFD_SIG;
                end
            end
            UCFD_SIG:
            begin
                st.req = 1'b1;
                if (st.ack)
                begin
                    valid_d = (st.data[7:0] == `UCFD_SIGNATURE);
                    state_d = UCFD_GEN;
                end
            end
            UCFD_GEN:
            begin
                st.req = valid_q;
                st.addr = 2'h1;
                if (!valid_q || st.ack)
                begin
                    loadGen = 1'b1;
                    useDefault = !valid_q;
                    state_d = UCFD_TX;
                end
            end
            UCFD_TX:
            begin
                st.req = valid_q;
                st.addr = 2'h2;
                if (!valid_q || st.ack)
                begin
                    loadTx = 1'b1;
                    useDefault = !valid_q;
                    state_d = UCFD_DONE;
                end
            end
            UCFD_DONE:
            begin
                if (start)
                begin
                    state_d = UCFD_SIG;
                end
            end
            default:
            begin
                state_d = UCFD_IDLE;
            end
        endcase
        busy = (state_q != UCFD_IDLE) && (state_q != UCFD_DONE);
    end

    // State registers
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= UCFD_IDLE;
            valid_q <= 1'b0;
        end
        else if (clkEn)
        begin
            state_q <= state_d;
            valid_q <= valid_d;
        end
    end

endmodule // ucfd_loader
`default_nettype wire

// ===== ucfd_decode.sv
// Config flag decoder: two configuration words, APB access, decoded controls.
// Assumes synchronous inputs on sys_clk and a word-wide store read port.
//
// How it works
// RL1: Swap bit exchanges positive and negative pads.
// RL2: Swap only on USB 2.0 pads.
// RL3: Bit 11 sets switch-mode input level.
// RL4: Bit 10 picks open-drain or push/pull light.
// RL5: Bit 9 sets indicator light active level.
// RL6: Bit 8 enables the indicator light.
// RL7: Bit 7 sets interrupt pin level.
// RL8: Bit 6 sets external reset level.
// RL9: Field 5:4 drives squelch reference control.
// RL10: Bit 3 enables link power management.
// RL11: Field 2:1 drives high-speed boost.
// RL12: Bit 0 selects bus or self power.
// RL13: Programmer keeps flags matching stored descriptors.
// RL14: Field 29:24 used when de-emphasis select high.
// RL15: Field 21:16 used when de-emphasis select low.
// RL16: Field 14:8 amplitude in full swing.
// RL17: Field 6:0 amplitude in low swing.
// RL18: Words load from store after reset.
// RL19: No valid store gives hardware defaults.
// RL20: Reserved bits never reach any output.
// RL21: Outputs change only on captured loads and APB writes.
`timescale 1ns/1ps
`default_nettype none
`include "ucfd_map.svh"
module ucfd_decode
    import ucfd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Store read port
    output logic storeReq,
    output logic [1:0] storeAddr,
    input wire logic storeAck,
    input wire logic [31:0] storeData,
    // Mode controls
    input wire logic usb3Active,
    input wire logic txDeemphSel,
    input wire logic txSwingSel,
    // Pads and pins
    input wire logic dpPadIn,
    input wire logic dmPadIn,
    output logic dpLineOut,
    output logic dmLineOut,
    input wire logic switchModeInput,
    output logic switchModeActive,
    input wire logic ledRequest,
    output logic ledOut,
    output logic ledOe_b,
    input wire logic irqRequest,
    output logic irqPin,
    input wire logic externalResetInput,
    output logic externalResetActive,
    // Decoded controls
    output logic [1:0] squelchSel,
    output logic lpmEnable,
    output logic [1:0] hsDriveBoost,
    output logic selfPowered,
    output logic [5:0] txDeemph,
    output logic [6:0] txAmplitude,
    output logic configReady
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    ucfd_word_t gen_q;
    ucfd_word_t gen_d;
    ucfd_word_t tx_q;
    ucfd_word_t tx_d;
    logic ready_q;
    logic ready_d;
    logic usedDefault_q;
    logic usedDefault_d;
    logic startLoad_q;
    logic startLoad_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Loader strobes and APB decode terms
    logic loadGen;
    logic loadTx;
    logic useDefault;
    logic busy;
    logic apbWrite;
    logic apbRead;
    logic hitGen;
    logic hitTx;
    logic hitCtrl;
    logic hitStatus;
    logic swap;

    ucfd_store_if st ();

    // Decode one APB address against a register offset
    function automatic logic addrHit(input logic [11:0] a, input logic [11:0] off);
        addrHit = (a == off);
    endfunction

    // ****************************************************************
    // Loader
    // ****************************************************************
    // Sequencer fetching signature, then both words if it matches
    ucfd_loader ucfd_loader_i
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .start(startLoad_q),
        .st(st.loader),
        .loadGen(loadGen),
        .loadTx(loadTx),
        .useDefault(useDefault),
        .busy(busy)
    );

    // Store port pass-out
    assign storeReq = st.req;
    assign storeAddr = st.addr;
    assign st.ack = storeAck;
    assign st.data = storeData;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // Zero-wait slave; unmapped gives error
    // With clkEn low an access still ends but is dropped
    always_comb
    begin
        hitGen = 1'b0;
        hitTx = 1'b0;
        hitCtrl = 1'b0;
        hitStatus = 1'b0;
        if (addrHit(paddr, `UCFD_OFF_GENERAL))
        begin
            hitGen = 1'b1;
        end
        else if (addrHit(paddr, `UCFD_OFF_TXTUNE))
        begin
            hitTx = 1'b1;
        end
        else if (addrHit(paddr, `UCFD_OFF_CTRL))
        begin
            hitCtrl = 1'b1;
        end
        else if (addrHit(paddr, `UCFD_OFF_STATUS))
        begin
            hitStatus = 1'b1;
        end
        apbWrite = psel && penable && pwrite && clkEn;
        apbRead = psel && !penable && !pwrite;
        pready = 1'b1;
        pslverr = psel && penable && !(hitGen || hitTx || hitCtrl || hitStatus);
    end

    // ****************************************************************
    // Register next values
    // ****************************************************************
    // Next values of words, flags and read data
    always_comb
    begin
        gen_d = gen_q;
        tx_d = tx_q;
        ready_d = ready_q;
        usedDefault_d = usedDefault_q;
        startLoad_d = 1'b0;
        rdata_d = rdata_q;
        // Loads from store or defaults; only these and APB writes move outputs
        if (loadGen)
        begin
            gen_d = useDefault ? `UCFD_GEN_DEFAULT : (storeData & `UCFD_GEN_MASK); // RL18 RL19 RL21
            usedDefault_d = useDefault; // RL19
        end
        if (loadTx)
        begin
            tx_d = useDefault ? `UCFD_TX_DEFAULT : (storeData & `UCFD_TX_MASK); // RL18 RL19 RL21
            ready_d = 1'b1; // RL18
        end

        // APB writes follow loads so a write wins
        if (apbWrite && hitGen)
        begin
            gen_d = pwdata & `UCFD_GEN_MASK; // RL20
        end
        if (apbWrite && hitTx)
        begin
            tx_d = pwdata & `UCFD_TX_MASK; // RL20
        end
        // Reload is taken only when the loader is idle or done
        if (apbWrite && hitCtrl && pwdata[`UCFD_CTRL_RELOAD])
        begin
            startLoad_d = 1'b1;
            ready_d = 1'b0;
        end

        // Read data captured in setup cycle
        if (apbRead)
        begin
            if (hitGen)
            begin
                rdata_d = gen_q;
            end
            else if (hitTx)
            begin
                rdata_d = tx_q;
            end
            else if (hitStatus)
            begin
                rdata_d = {29'h0, usedDefault_q, busy, ready_q};
            end
            else
            begin
                rdata_d = 32'h0;
            end
        end
    end

    // Reset holds the no-store defaults
    // Registers; reset kicks off the store load
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gen_q <= `UCFD_GEN_DEFAULT;
            tx_q <= `UCFD_TX_DEFAULT;
            ready_q <= 1'b0;
            usedDefault_q <= 1'b0;
            startLoad_q <= 1'b1; // RL18
            rdata_q <= 32'h0;
        end
        else if (clkEn)
        begin
            gen_q <= gen_d;
            tx_q <= tx_d;
            ready_q <= ready_d;
            usedDefault_q <= usedDefault_d;
            startLoad_q <= startLoad_d;
            rdata_q <= rdata_d;
        end
    end

    // Read data and ready straight from flops
    assign prdata = rdata_q;
    assign configReady = ready_q;

    // ****************************************************************
    // Pad and pin decode
    // ****************************************************************
    // Swap USB 2.0 pads only
    assign swap = gen_q[`UCFD_GEN_SWAP] && !usb3Active; // RL1 RL2
    assign dpLineOut = swap ? dmPadIn : dpPadIn; // RL1
    assign dmLineOut = swap ? dpPadIn : dmPadIn; // RL1

    // Pin polarities
    assign switchModeActive = switchModeInput ~^ gen_q[`UCFD_GEN_SWMODE_LVL]; // RL3
    assign irqPin = irqRequest ~^ gen_q[`UCFD_GEN_IRQ_LVL]; // RL7
    assign externalResetActive = externalResetInput ~^ gen_q[`UCFD_GEN_XRST_LVL]; // RL8

    // Indicator light driver
    always_comb
    begin
        logic lvl;
        lvl = 1'b0;
        lvl = (ledRequest && gen_q[`UCFD_GEN_LED_EN]) ~^ gen_q[`UCFD_GEN_LED_LVL]; // RL5 RL6
        if (gen_q[`UCFD_GEN_LED_PP])
        begin
            ledOut = lvl; // RL4
            ledOe_b = 1'b0;
        end
        else
        begin
            ledOut = 1'b0; // RL4
            ledOe_b = lvl;
        end
    end

    // Reserved bits are masked on capture
    // Decoded physical-layer controls
    assign squelchSel = gen_q[`UCFD_GEN_SQ_HI:`UCFD_GEN_SQ_LO]; // RL9
    assign lpmEnable = gen_q[`UCFD_GEN_LPM]; // RL10 RL13
    assign hsDriveBoost = gen_q[`UCFD_GEN_BOOST_HI:`UCFD_GEN_BOOST_LO]; // RL11
    assign selfPowered = gen_q[`UCFD_GEN_SELFPWR]; // RL12
    assign txDeemph = txDeemphSel ? tx_q[`UCFD_TX_DE35_HI:`UCFD_TX_DE35_LO]
                                  : tx_q[`UCFD_TX_DE6_HI:`UCFD_TX_DE6_LO]; // RL14 RL15
    assign txAmplitude = txSwingSel ? tx_q[`UCFD_TX_LOW_HI:`UCFD_TX_LOW_LO]
                                    : tx_q[`UCFD_TX_FULL_HI:`UCFD_TX_FULL_LO]; // RL16 RL17

endmodule // ucfd_decode
`default_nettype wire

// ===== ucfd_decode_properties.sv
// Checker: shadows both words and ties the decoded controls to them.
// Assumes a bind onto ucfd_decode, clkEn held high.
`timescale 1ns/1ps
`default_nettype none
`include "ucfd_map.svh"
module ucfd_decode_properties
    import ucfd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [1:0] storeAddr,
    input wire logic storeAck,
    input wire logic [31:0] storeData,
    input wire logic usb3Active,
    input wire logic txDeemphSel,
    input wire logic txSwingSel,
    input wire logic dpPadIn,
    input wire logic dmPadIn,
    input wire logic dpLineOut,
    input wire logic dmLineOut,
    input wire logic ledRequest,
    input wire logic ledOut,
    input wire logic ledOe_b,
    input wire logic irqRequest,
    input wire logic irqPin,
    input wire logic [1:0] squelchSel,
    input wire logic lpmEnable,
    input wire logic [1:0] hsDriveBoost,
    input wire logic selfPowered,
    input wire logic [5:0] txDeemph,
    input wire logic [6:0] txAmplitude,
    input wire logic configReady
);
    ucfd_word_t genQ, txQ;
    logic wrEn, ledLvl;
    assign wrEn = psel && penable && pwrite;
    assign ledLvl = ~((ledRequest & genQ[8]) ^ genQ[9]);
    // Shadow words, APB write wins over a store answer
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            genQ <= `UCFD_GEN_DEFAULT;
            txQ <= `UCFD_TX_DEFAULT;
        end
        else if (wrEn && paddr == `UCFD_OFF_GENERAL)
            genQ <= pwdata & `UCFD_GEN_MASK;
        else if (wrEn && paddr == `UCFD_OFF_TXTUNE)
            txQ <= pwdata & `UCFD_TX_MASK;
        else if (storeAck && storeAddr == 2'h1)
            genQ <= storeData & `UCFD_GEN_MASK;
        else if (storeAck && storeAddr == 2'h2)
            txQ <= storeData & `UCFD_TX_MASK;
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    chk_pad_swap_usb2: assert property (!usb3Active |->
        {dpLineOut, dmLineOut} == (genQ[12] ? {dmPadIn, dpPadIn} : {dpPadIn, dmPadIn}))
        else $error("pad mapping wrong in USB 2.0 mode");
    chk_no_swap_usb3: assert property (usb3Active |->
        dpLineOut == dpPadIn && dmLineOut == dmPadIn) else $error("pads swapped in USB 3 mode");
    chk_light_drive: assert property ({ledOut, ledOe_b} ==
        (genQ[10] ? {ledLvl, 1'b0} : {1'b0, ledLvl})) else $error("light output wrong");
    chk_irq_level: assert property (irqPin == ~(irqRequest ^ genQ[7]))
        else $error("interrupt pin level wrong");
    chk_general_fields: assert property (
        {squelchSel, lpmEnable, hsDriveBoost, selfPowered} == genQ[5:0])
        else $error("general word controls wrong");
    chk_deemph_pick: assert property (
        txDeemph == (txDeemphSel ? txQ[29:24] : txQ[21:16])) else $error("deemphasis wrong");
    chk_amp_pick: assert property (
        txAmplitude == (txSwingSel ? txQ[6:0] : txQ[14:8])) else $error("amplitude wrong");
    chk_ready_after_load: assert property (
        storeAck && storeAddr == 2'h2 |-> ##[1:2] configReady) else $error("ready late");
    chk_hold_controls: assert property (!storeAck && !wrEn |=>
        $stable({squelchSel, lpmEnable, hsDriveBoost, selfPowered})) else $error("drift");
    cov_load_done: cover property (storeAck && storeAddr == 2'h2);
    cov_swapped: cover property (!usb3Active && genQ[12]);
    cov_low_swing: cover property (txSwingSel && !txDeemphSel);
endmodule // ucfd_decode_properties

bind ucfd_decode ucfd_decode_properties ucfd_decode_properties_i
(
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .storeAddr(storeAddr), .storeAck(storeAck),
    .storeData(storeData), .usb3Active(usb3Active), .txDeemphSel(txDeemphSel),
    .txSwingSel(txSwingSel), .dpPadIn(dpPadIn), .dmPadIn(dmPadIn), .dpLineOut(dpLineOut),
    .dmLineOut(dmLineOut), .ledRequest(ledRequest), .ledOut(ledOut), .ledOe_b(ledOe_b),
    .irqRequest(irqRequest), .irqPin(irqPin), .squelchSel(squelchSel), .lpmEnable(lpmEnable),
    .hsDriveBoost(hsDriveBoost), .selfPowered(selfPowered), .txDeemph(txDeemph),
    .txAmplitude(txAmplitude), .configReady(configReady)
);
`default_nettype wire

// ===== ucfd_store_model.sv
// Store model: answers each held request with a one-cycle ack.
// Assumes the loader holds request and address until the ack.
`timescale 1ns/1ps
`default_nettype none
module ucfd_store_model
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic storeReq,
    input wire logic [1:0] storeAddr,
    input wire logic [3:0] lat,
    input wire logic [31:0] sigWord,
    input wire logic [31:0] genWord,
    input wire logic [31:0] txWord,
    output logic storeAck,
    output logic [31:0] storeData
);
    logic [3:0] waitQ;
    // Wait lat cycles, ack once; data scrambled when not acking
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            waitQ <= 4'h0;
            storeAck <= 1'b0;
            storeData <= 32'h0;
        end
        else if (storeReq && !storeAck && waitQ >= lat)
        begin
            waitQ <= 4'h0;
            storeAck <= 1'b1;
            storeData <= (storeAddr == 2'h0) ? sigWord : (storeAddr == 2'h1) ? genWord : txWord;
        end
        else
        begin
            waitQ <= (storeReq && !storeAck) ? waitQ + 4'h1 : 4'h0;
            storeAck <= 1'b0;
            storeData <= ~storeData; // No stale value once released
        end
    end
endmodule // ucfd_store_model
`default_nettype wire

// ===== ucfd_decode_tb_top.sv
// Testbench: APB master, store model, scoreboard queue.
// Assumes the design, store model and checker compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "ucfd_map.svh"
module ucfd_decode_tb_top
    import ucfd_pkg::*;
;
    logic sys_clk, rst_b, psel, penable, pwrite, probe, pready, pslverr;
    logic storeReq, storeAck, configReady, u3, dsel, ssel, dp, dm, swi, lreq, ireq, xri;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, storeData, sigW, genW, txW, seed, gExp, tExp;
    logic [3:0] lat;
    logic [1:0] storeAddr;
    logic [25:0] obs;
    logic [32:0] expQ[$];
    int errorCnt, nTests;
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    ucfd_decode ucfd_decode_i
    (
        .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .storeReq(storeReq), .storeAddr(storeAddr), .storeAck(storeAck),
        .storeData(storeData), .usb3Active(u3), .txDeemphSel(dsel), .txSwingSel(ssel),
        .dpPadIn(dp), .dmPadIn(dm), .dpLineOut(obs[25]), .dmLineOut(obs[24]),
        .switchModeInput(swi), .switchModeActive(obs[23]), .ledRequest(lreq),
        .ledOut(obs[22]), .ledOe_b(obs[21]), .irqRequest(ireq), .irqPin(obs[20]),
        .externalResetInput(xri), .externalResetActive(obs[19]), .squelchSel(obs[18:17]),
        .lpmEnable(obs[16]), .hsDriveBoost(obs[15:14]), .selfPowered(obs[13]),
        .txDeemph(obs[12:7]), .txAmplitude(obs[6:0]), .configReady(configReady)
    );
    ucfd_store_model ucfd_store_model_i
    (
        .sys_clk(sys_clk), .rst_b(rst_b), .storeReq(storeReq), .storeAddr(storeAddr),
        .lat(lat), .sigWord(sigW), .genWord(genW), .txWord(txW), .storeAck(storeAck),
        .storeData(storeData)
    );
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected controls from words and the pin vector
    function automatic logic [25:0] expo(input logic [31:0] g, input logic [31:0] t,
                                         input logic [8:0] i);
        logic sw, lv;
        sw = g[12] && !i[8];
        lv = ~((i[2] & g[8]) ^ g[9]);
        return {sw ? i[4] : i[5], sw ? i[5] : i[4], i[3] == g[11], g[10] & lv, ~g[10] & lv,
                ~(i[1] ^ g[7]), i[0] == g[6], g[5:0], i[7] ? t[29:24] : t[21:16],
                i[6] ? t[6:0] : t[14:8]};
    endfunction
    task automatic check(input string nm, input logic [32:0] e, input logic [32:0] s);
        nTests++;
        if (s !== e)
        begin
            errorCnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    // Monitor: pops the oldest note when a read or probe shows up
    always @(posedge sys_clk)
    begin
        if (psel && penable && !pwrite && pready)
            check("prdata", expQ.pop_front(), {pslverr, prdata});
        if (probe)
            check("controls", expQ.pop_front(), {7'h00, obs});
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            expQ.push_back(e);
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge sys_clk);
        end
        errorCnt += (n == 20);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Read both words back, then probe the controls twice
    task automatic check_words();
        logic [31:0] r;
        apb(1'b0, `UCFD_OFF_GENERAL, 32'h0, {1'b0, gExp});
        apb(1'b0, `UCFD_OFF_TXTUNE, 32'h0, {1'b0, tExp});
        repeat (2)
        begin
            r = xs();
            {u3, dsel, ssel, dp, dm, swi, lreq, ireq, xri} <= r[8:0];
            expQ.push_back({7'h00, expo(gExp, tExp, r[8:0])});
            probe <= 1'b1;
            @(posedge sys_clk);
            probe <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task automatic wait_ready();
        int n;
        for (n = 0; n < 300 && configReady !== 1'b1; n++)
            @(posedge sys_clk);
        errorCnt += (n == 300);
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errorCnt++;
        completeRun();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {psel, penable, pwrite, probe, rst_b} = 5'h00;
        {u3, dsel, ssel, dp, dm, swi, lreq, ireq, xri} = 9'h000;
        {paddr, pwdata, errorCnt, nTests, seed, lat, sigW} = {44'h0, 64'h0, 32'h37B7, 36'h2};
        genW = xs();
        txW = xs();
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        gExp = `UCFD_GEN_DEFAULT;
        tExp = `UCFD_TX_DEFAULT;
        wait_ready();
        apb(1'b0, `UCFD_OFF_STATUS, 32'h0, 33'h5);
        check_words();
        $display("test defaults done");
        sigW <= {24'h0, `UCFD_SIGNATURE};
        lat <= 4'h5;
        gExp = xs() | 32'h8;
        genW <= gExp;
        gExp = gExp & `UCFD_GEN_MASK;
        tExp = txW & `UCFD_TX_MASK;
        rst_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        wait_ready();
        apb(1'b0, `UCFD_OFF_STATUS, 32'h0, 33'h1);
        check_words();
        $display("test store load done");
        for (int i = 0; i < 16; i++)
        begin
            gExp = xs();
            gExp[5:4] = i[1:0];
            gExp[2:1] = i[3:2];
            tExp = xs();
            apb(1'b1, `UCFD_OFF_GENERAL, gExp, 33'h0);
            apb(1'b1, `UCFD_OFF_TXTUNE, tExp, 33'h0);
            gExp = gExp & `UCFD_GEN_MASK;
            tExp = tExp & `UCFD_TX_MASK;
            check_words();
        end
        $display("test decode done");
        apb(1'b1, 12'h010, 32'hFFFFFFFF, 33'h0);
        apb(1'b0, 12'hFFC, 32'h0, 33'h100000000);
        apb(1'b0, `UCFD_OFF_GENERAL, 32'h0, {1'b0, gExp});
        $display("test unmapped done");
        apb(1'b1, `UCFD_OFF_CTRL, 32'h1, 33'h0);
        gExp = genW & `UCFD_GEN_MASK;
        tExp = txW & `UCFD_TX_MASK;
        wait_ready();
        check_words();
        $display("test reload done");
        completeRun();
    end
endmodule // ucfd_decode_tb_top
`default_nettype wire
